// *** hw/pds_dev.sv ***
// Purpose: Position demand selector, redundant command sources to setpoint
// Assumes: Link inputs synchronous to clk; config ports held static
// Notes:   Outputs registered; selection advances once per tick
module pds_dev #(
  parameter int TICK_CYC = pds_pkg::TICK_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  pds_link_if.dev                lk,
  input  pds_pkg::pds_src_e      pri_src,
  input  pds_pkg::pds_src_e      bak_src,
  input  pds_pkg::pds_rng_e      ana_range,
  input  wire logic [11:0]       ana_fail_lo,
  input  wire logic [11:0]       ana_fail_hi,
  input  wire logic              pwm_lowside,
  input  wire logic [18:0]       pwm_per_min,
  input  wire logic [18:0]       pwm_per_max,
  input  wire logic [12:0]       pwm_duty_min,
  input  wire logic [12:0]       pwm_duty_max,
  input  wire logic signed [11:0] pwm_duty_ofs,
  input  wire logic [11:0]       pwm_duty_zero,
  input  wire logic [11:0]       pwm_duty_gain,
  input  wire logic [15:0]       can_tmo,
  input  wire logic [11:0]       trk_max_diff,
  input  wire logic              trk_use_bak,
  input  wire logic [11:0]       fb_tol,
  input  wire logic [15:0]       fb_dly,
  input  wire logic              flt_en,
  input  wire logic [3:0]        flt_shift,
  input  wire logic              lut_en,
  input  wire logic [10:0][11:0] lut_x,
  input  wire logic [10:0][11:0] lut_y,
  input  wire logic              fault_sd,
  input  wire logic              sd_to_pos,
  input  wire logic [11:0]       sd_pos,
  output logic [11:0]            pos_dmd,
  output logic                   dmd_valid,
  output pds_pkg::pds_st_e       op_status,
  output logic                   cmd_alarm,
  output logic                   cmd_shutdown,
  output logic                   limp,
  output logic                   src_alarm,
  output logic                   trk_err,
  output logic                   pri_fail,
  output logic                   bak_fail
);
  typedef struct packed {
    logic [19:0]      tick_cnt;
    logic             tick, pin_q, pvalid, valid, alarm, sd, limp, salarm, trk, pfail, bfail;
    logic [18:0]      pcnt, hcnt, pper, phi;
    logic [11:0]      can_pos, sel, flt, out;
    logic [15:0]      can_age, fb_cnt;
    pds_pkg::pds_st_e st;
  } pds_dev_s;

  pds_dev_s s, n;

  function automatic logic [11:0] pds_clamp(int v);
    if (v < 0) return 12'h000;
    if (v > pds_pkg::POS_MAX) return 12'hfff;
    return 12'(v);
  endfunction : pds_clamp

  // Linear interpolation over strictly increasing breakpoints
  function automatic logic [11:0] pds_lut(logic [11:0] x, logic [10:0][11:0] xs, logic [10:0][11:0] ys);
    int r;
    r = int'(ys[0]);
    if (x >= xs[10]) begin
      r = int'(ys[10]);
    end else if (x > xs[0]) begin
      for (int i = 0; i < 10; i++) begin
        if (x >= xs[i] && x < xs[i+1]) begin
          r = int'(ys[i]) + ((int'(x) - int'(xs[i])) * (int'(ys[i+1]) - int'(ys[i])))
              / (int'(xs[i+1]) - int'(xs[i]));
        end
      end
    end
    return pds_clamp(r);
  endfunction : pds_lut

  // Whole selector; divides are combinational, traded area for simplicity
  always_comb begin
    int               duty, pwm_v, ana_v, pv, bv, dif, dmd;
    logic             act, pwm_ok, ana_ok, can_ok, p_ok, b_ok, red, on_bak, trk;
    pds_pkg::pds_st_e nst;
    duty   = 0;
    pwm_v  = 0;
    ana_v  = 0;
    pv     = 0;
    bv     = 0;
    dif    = 0;
    dmd    = 0;
    act    = 1'b0;
    pwm_ok = 1'b0;
    ana_ok = 1'b0;
    can_ok = 1'b0;
    p_ok   = 1'b0;
    b_ok   = 1'b0;
    red    = 1'b0;
    on_bak = 1'b0;
    trk    = 1'b0;
    nst    = s.st;
    n      = s;
    // Fixed evaluation tick
    n.tick = 1'b0;
    if (s.tick_cnt >= 20'(TICK_CYC - 1)) begin
      n.tick_cnt = 20'h0_0000;
      n.tick     = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 20'h0_0001;
    end
    // PWM period and on time, measured rising to rising
    act     = pwm_lowside ? ~lk.pwm_pin : lk.pwm_pin;
    n.pin_q = act;
    if (act && !s.pin_q) begin
      n.pper   = s.pcnt;
      n.phi    = s.hcnt;
      n.pvalid = s.pcnt >= 19'(pds_pkg::PER_MIN_CYC) && s.pcnt <= 19'(pds_pkg::PER_MAX_CYC);
      n.pcnt   = 19'h0_0001;
      n.hcnt   = 19'h0_0001;
    end else begin
      if (s.pcnt != '1) n.pcnt = s.pcnt + 19'h0_0001;
      if (act && s.hcnt != '1) n.hcnt = s.hcnt + 19'h0_0001;
      if (s.pcnt > 19'(pds_pkg::PER_MAX_CYC)) n.pvalid = 1'b0;
    end
    if (s.pper != '0) duty = (int'(s.phi) * pds_pkg::DUTY_FULL) / int'(s.pper);
    duty   = duty + int'(pwm_duty_ofs);
    pwm_ok = s.pvalid && s.pper >= pwm_per_min && s.pper <= pwm_per_max
             && duty >= int'(pwm_duty_min) && duty <= int'(pwm_duty_max);
    pwm_v  = ((duty - int'(pwm_duty_zero)) * int'(pwm_duty_gain)) >>> pds_pkg::GAIN_SHIFT;
    // Analog level, live zero only on the current loop range
    ana_ok = lk.ana_code >= ana_fail_lo && lk.ana_code <= ana_fail_hi;
    ana_v  = (ana_range == pds_pkg::RNG_420)
             ? ((int'(lk.ana_code) - int'(pds_pkg::ANA_ZERO_420)) * pds_pkg::ANA_GAIN_420) >>> pds_pkg::GAIN_SHIFT
             : int'(lk.ana_code);
    // CAN freshness counted in ticks, stale from reset
    if (lk.can_upd) begin
      n.can_pos = lk.can_pos;
      n.can_age = 16'h0000;
    end else if (s.tick && s.can_age != '1) begin
      n.can_age = s.can_age + 16'h0001;
    end
    can_ok = s.can_age < can_tmo;
    // Source routing
    unique case (pri_src)
      pds_pkg::SRC_CAN: begin pv = int'(s.can_pos); p_ok = can_ok; end
      pds_pkg::SRC_PWM: begin pv = int'(pds_clamp(pwm_v)); p_ok = pwm_ok; end
      pds_pkg::SRC_ANA: begin pv = int'(pds_clamp(ana_v)); p_ok = ana_ok; end
      default:          begin pv = 0; p_ok = 1'b0; end
    endcase
    unique case (bak_src)
      pds_pkg::SRC_CAN: begin bv = int'(s.can_pos); b_ok = can_ok; end
      pds_pkg::SRC_PWM: begin bv = int'(pds_clamp(pwm_v)); b_ok = pwm_ok; end
      pds_pkg::SRC_ANA: begin bv = int'(pds_clamp(ana_v)); b_ok = ana_ok; end
      default:          begin bv = 0; b_ok = 1'b0; end
    endcase
    red    = bak_src != pds_pkg::SRC_NONE;
    dif    = (pv > bv) ? pv - bv : bv - pv;
    trk    = p_ok && b_ok && dif > int'(trk_max_diff);
    on_bak = s.st inside {pds_pkg::ST_BAK_PFAIL, pds_pkg::ST_BAK_PNTRK, pds_pkg::ST_FB_INHIB, pds_pkg::ST_FB_PEND};
    // Selection state, advanced once per tick
    if (s.tick) begin
      n.fb_cnt = 16'h0000;
      if (!p_ok && !b_ok) begin
        nst = pds_pkg::ST_ALL_FAIL;
      end else if (!p_ok) begin
        nst = pds_pkg::ST_BAK_PFAIL;
      end else if (!b_ok) begin
        nst = red ? pds_pkg::ST_PRI_BFAIL : pds_pkg::ST_PRI;
      end else if (trk) begin
        nst = trk_use_bak ? pds_pkg::ST_BAK_PNTRK : pds_pkg::ST_PRI_BNTRK;
      end else if (on_bak && dif > int'(fb_tol)) begin
        nst = pds_pkg::ST_FB_INHIB;
      end else if (on_bak && s.fb_cnt < fb_dly) begin
        nst      = pds_pkg::ST_FB_PEND;
        n.fb_cnt = s.fb_cnt + 16'h0001;
      end else begin
        nst = pds_pkg::ST_PRI;
      end
      n.st = nst;
      unique case (nst)
        pds_pkg::ST_PRI, pds_pkg::ST_PRI_BFAIL, pds_pkg::ST_PRI_BNTRK: dmd = pv;
        pds_pkg::ST_ALL_FAIL:                                          dmd = int'(s.sel);
        default:                                                       dmd = bv;
      endcase
      n.sel    = pds_clamp(dmd);
      n.flt    = flt_en ? pds_clamp(int'(s.flt) + ((dmd - int'(s.flt)) >>> flt_shift)) : pds_clamp(dmd);
      n.valid  = 1'b1;
      n.trk    = trk;
      n.pfail  = !p_ok;
      n.bfail  = red && !b_ok;
      n.salarm = red && (p_ok != b_ok);
      n.alarm  = nst == pds_pkg::ST_ALL_FAIL && !fault_sd;
      n.sd     = nst == pds_pkg::ST_ALL_FAIL && fault_sd;
    end
    // Output stage: curve, then shutdown override
    n.limp = n.sd && !sd_to_pos;
    if (s.sd) begin
      n.out = sd_to_pos ? sd_pos : s.out;
    end else begin
      n.out = lut_en ? pds_lut(s.flt, lut_x, lut_y) : s.flt;
    end
  end

  // Reset leaves CAN stale, PWM unmeasured and status all failed
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s         <= '0;
      s.can_age <= '1;
      s.st      <= pds_pkg::ST_ALL_FAIL;
    end else begin
      s <= n;
    end
  end

  assign pos_dmd      = s.out;
  assign dmd_valid    = s.valid;
  assign op_status    = s.st;
  assign cmd_alarm    = s.alarm;
  assign cmd_shutdown = s.sd;
  assign limp         = s.limp;
  assign src_alarm    = s.salarm;
  assign trk_err      = s.trk;
  assign pri_fail     = s.pfail;
  assign bak_fail     = s.bfail;
endmodule : pds_dev

// *** hw/pds_pkg.sv ***
// Purpose: Shared constants and types for the position demand selector
// Assumes: 40 MHz system clock, 12-bit position scale (0..4095 = 0..100 %)
// Notes:   Host register map sits at word-aligned byte offsets
package pds_pkg;
  // Clock and evaluation tick
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYC    = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int STARTUP_MS  = 350;
  // PWM frequency window accepted by the decoder
  localparam int PWM_FMIN_HZ = 100;
  localparam int PWM_FMAX_HZ = 3000;
  localparam int PER_MAX_CYC = CLK_HZ / PWM_FMIN_HZ;
  localparam int PER_MIN_CYC = (CLK_HZ + PWM_FMAX_HZ - 1) / PWM_FMAX_HZ;
  localparam int PW          = 19;
  localparam int DUTY_FULL   = 4096;
  localparam int POS_MAX     = 4095;
  localparam int GAIN_SHIFT  = 8;
  // Analog range scaling, 4-20 mA has a live zero
  localparam logic [11:0] ANA_ZERO_420 = 12'h0333;
  localparam int          ANA_GAIN_420 = 320;

  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_CAN  = 2'h1,
    SRC_PWM  = 2'h2,
    SRC_ANA  = 2'h3
  } pds_src_e;

  typedef enum logic [1:0] {
    RNG_420 = 2'h0,
    RNG_200 = 2'h1,
    RNG_5V  = 2'h2
  } pds_rng_e;

  // Operating status, one-hot
  typedef enum logic [7:0] {
    ST_PRI       = 8'h01,
    ST_PRI_BFAIL = 8'h02,
    ST_PRI_BNTRK = 8'h04,
    ST_BAK_PFAIL = 8'h08,
    ST_BAK_PNTRK = 8'h10,
    ST_FB_INHIB  = 8'h20,
    ST_FB_PEND   = 8'h40,
    ST_ALL_FAIL  = 8'h80
  } pds_st_e;

  // Host register map (byte offsets) and fields
  localparam logic [4:0]  OFS_CTRL     = 5'h00;
  localparam logic [4:0]  OFS_CAN_POS  = 5'h04;
  localparam logic [4:0]  OFS_CAN_PER  = 5'h08;
  localparam logic [4:0]  OFS_PWM_PER  = 5'h0c;
  localparam logic [4:0]  OFS_PWM_HIGH = 5'h10;
  localparam logic [4:0]  OFS_ANA      = 5'h14;
  localparam logic [4:0]  OFS_STAT     = 5'h18;
  localparam int          CTRL_CAN_EN  = 0;
  localparam int          CTRL_PWM_EN  = 1;
  localparam int          CTRL_PWM_PP  = 2;
  localparam logic [31:0] CAN_PER_RST  = 32'h0000_9c40;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : pds_pkg

// *** hw/pds_link_if.sv ***
// Purpose: Command link between engine controller and demand selector
// Assumes: PWM line has a pull-up; low-side source only sinks
// Notes:   Interface resolves the PWM wire level from the enable
interface pds_link_if;
  logic        can_upd;
  logic [11:0] can_pos;
  logic        pwm_o;
  logic        pwm_oe;
  logic        pwm_pin;
  logic [11:0] ana_code;

  // Released line floats high
  assign pwm_pin = pwm_oe ? pwm_o : 1'b1;

  modport dev  (input  can_upd, can_pos, pwm_pin, ana_code);
  modport host (output can_upd, can_pos, pwm_o, pwm_oe, ana_code);
endinterface : pds_link_if

// *** hw/pds_host.sv ***
// Purpose: Engine controller end, sends CAN, PWM and analog commands
// Assumes: Software programs it over AXI4-Lite, 32-bit words
// Notes:   One write and one read in flight; unmapped answers SLVERR
module pds_host (
  input  wire logic        clk,
  input  wire logic        arst_n,
  pds_link_if.host         lk,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef struct packed {
    logic        awrdy, wrdy, bvalid, arrdy, rvalid, aw_got, w_got;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [4:0]  awa;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic [2:0]  ctrl;
    logic [11:0] can_val, ana;
    logic [31:0] can_per, pwm_per, pwm_hi, can_cnt, pwm_cnt;
    logic [15:0] sent;
    logic        can_upd, pwm_o, pwm_oe;
    logic [11:0] can_pos;
  } pds_host_s;

  pds_host_s s, n;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] pds_merge(logic [31:0] old, logic [31:0] d, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : pds_merge

  // Bus slave and command generation
  always_comb begin
    logic on;
    on = 1'b0;
    n  = s;
    // Write address and data accepted in either order
    if (s_axi_awvalid && s.awrdy) begin
      n.aw_got = 1'b1;
      n.awa    = s_axi_awaddr;
      n.awrdy  = 1'b0;
    end
    if (s_axi_wvalid && s.wrdy) begin
      n.w_got = 1'b1;
      n.wd    = s_axi_wdata;
      n.ws    = s_axi_wstrb;
      n.wrdy  = 1'b0;
    end
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = pds_pkg::RESP_OKAY;
      unique case (s.awa)
        pds_pkg::OFS_CTRL:     n.ctrl    = 3'(pds_merge({29'h0, s.ctrl}, s.wd, s.ws));
        pds_pkg::OFS_CAN_POS:  n.can_val = 12'(pds_merge({20'h0, s.can_val}, s.wd, s.ws));
        pds_pkg::OFS_CAN_PER:  n.can_per = pds_merge(s.can_per, s.wd, s.ws);
        pds_pkg::OFS_PWM_PER:  n.pwm_per = pds_merge(s.pwm_per, s.wd, s.ws);
        pds_pkg::OFS_PWM_HIGH: n.pwm_hi  = pds_merge(s.pwm_hi, s.wd, s.ws);
        pds_pkg::OFS_ANA:      n.ana     = 12'(pds_merge({20'h0, s.ana}, s.wd, s.ws));
        default:               n.bresp   = pds_pkg::RESP_SLVERR;
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
      n.awrdy  = 1'b1;
      n.wrdy   = 1'b1;
    end
    // Read answers on the same edge that takes the address
    if (s_axi_arvalid && s.arrdy) begin
      n.arrdy  = 1'b0;
      n.rvalid = 1'b1;
      n.rresp  = pds_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        pds_pkg::OFS_CTRL:     n.rdata = {29'h0, s.ctrl};
        pds_pkg::OFS_CAN_POS:  n.rdata = {20'h0, s.can_val};
        pds_pkg::OFS_CAN_PER:  n.rdata = s.can_per;
        pds_pkg::OFS_PWM_PER:  n.rdata = s.pwm_per;
        pds_pkg::OFS_PWM_HIGH: n.rdata = s.pwm_hi;
        pds_pkg::OFS_ANA:      n.rdata = {20'h0, s.ana};
        pds_pkg::OFS_STAT:     n.rdata = {16'h0, s.sent};
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = pds_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
      n.arrdy  = 1'b1;
    end
    // Periodic CAN demand; period must beat the device timeout
    n.can_upd = 1'b0;
    if (s.ctrl[pds_pkg::CTRL_CAN_EN]) begin
      if (s.can_cnt + 32'h0000_0001 >= s.can_per) begin
        n.can_cnt = 32'h0000_0000;
        n.can_upd = 1'b1;
        n.can_pos = s.can_val;
        n.sent    = s.sent + 16'h0001;
      end else begin
        n.can_cnt = s.can_cnt + 32'h0000_0001;
      end
    end else begin
      n.can_cnt = 32'h0000_0000;
    end
    // PWM generator, low-side only sinks during the on time
    if (s.ctrl[pds_pkg::CTRL_PWM_EN]) begin
      n.pwm_cnt = (s.pwm_cnt + 32'h0000_0001 >= s.pwm_per) ? 32'h0000_0000 : s.pwm_cnt + 32'h0000_0001;
      on = s.pwm_cnt < s.pwm_hi;
    end else begin
      n.pwm_cnt = 32'h0000_0000;
    end
    n.pwm_o  = s.ctrl[pds_pkg::CTRL_PWM_PP] ? on : 1'b0;
    n.pwm_oe = s.ctrl[pds_pkg::CTRL_PWM_PP] ? s.ctrl[pds_pkg::CTRL_PWM_EN] : on;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s         <= '0;
      s.awrdy   <= 1'b1;
      s.wrdy    <= 1'b1;
      s.arrdy   <= 1'b1;
      s.can_per <= pds_pkg::CAN_PER_RST;
    end else begin
      s <= n;
    end
  end

  assign s_axi_awready = s.awrdy;
  assign s_axi_wready  = s.wrdy;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arrdy;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign lk.can_upd    = s.can_upd;
  assign lk.can_pos    = s.can_pos;
  assign lk.pwm_o      = s.pwm_o;
  assign lk.pwm_oe     = s.pwm_oe;
  assign lk.ana_code   = s.ana;
endmodule : pds_host

// *** sim/pds_asserts.sv ***
// Purpose: Temporal checks on the command link and selector status
// Assumes: One clock, async active-low reset
// Notes:   Flags are compared with the status word of the same cycle
module pds_asserts (
  input wire logic         clk,
  input wire logic         arst_n,
  input wire logic         can_upd,
  input pds_pkg::pds_st_e  op_status,
  input wire logic         dmd_valid,
  input wire logic         cmd_alarm,
  input wire logic         cmd_shutdown,
  input wire logic         limp,
  input wire logic         src_alarm,
  input wire logic         trk_err,
  input wire logic         pri_fail,
  input wire logic         bak_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // Status is always exactly one state
  property p_onehot; $onehot(op_status); endproperty
  a_onehot: assert property (p_onehot) else $error("status not one-hot");
  // First demand well inside the start-up window
  property p_start; $rose(arst_n) |-> ##[1:300] dmd_valid; endproperty
  a_start: assert property (p_start) else $error("no demand after reset");
  property p_keep; dmd_valid |=> dmd_valid; endproperty
  a_keep: assert property (p_keep) else $error("demand valid dropped");
  // Guarded by valid: reset state shows all-failed with flags low
  property p_all;
    dmd_valid && op_status == pds_pkg::ST_ALL_FAIL |-> cmd_alarm || cmd_shutdown;
  endproperty
  a_all: assert property (p_all) else $error("all failed without fault");
  property p_bpf; op_status == pds_pkg::ST_BAK_PFAIL |-> pri_fail && src_alarm; endproperty
  a_bpf: assert property (p_bpf) else $error("backup control without primary fault");
  property p_pbf; op_status == pds_pkg::ST_PRI_BFAIL |-> bak_fail && src_alarm; endproperty
  a_pbf: assert property (p_pbf) else $error("backup fault not flagged");
  property p_trk;
    op_status inside {pds_pkg::ST_PRI_BNTRK, pds_pkg::ST_BAK_PNTRK} |-> trk_err;
  endproperty
  a_trk: assert property (p_trk) else $error("tracking error not flagged");
  property p_pulse; can_upd |=> !can_upd; endproperty
  a_pulse: assert property (p_pulse) else $error("update pulse too long");
  property p_limp; limp |-> cmd_shutdown; endproperty
  a_limp: assert property (p_limp) else $error("limp without shutdown");

  // Main scenarios reached
  c_pend: cover property (op_status == pds_pkg::ST_FB_PEND);
  c_inhib: cover property (op_status == pds_pkg::ST_FB_INHIB);
  c_shut: cover property (cmd_shutdown && !limp);
endmodule : pds_asserts

// *** sim/pds_test.sv ***
// Purpose: Both ends joined, host driven over AXI4-Lite
// Assumes: Short tick of 50 clocks
// Notes:   Checks taken at the falling edge, outputs settled
module pds_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK = 50;
  logic clk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  pds_pkg::pds_src_e pri_src, bak_src;
  pds_pkg::pds_rng_e ana_range;
  logic [11:0] ana_fail_lo, ana_fail_hi, pwm_duty_zero, pwm_duty_gain, trk_max_diff, fb_tol, sd_pos, pos_dmd;
  logic signed [11:0] pwm_duty_ofs;
  logic [18:0] pwm_per_min, pwm_per_max;
  logic [12:0] pwm_duty_min, pwm_duty_max;
  logic [15:0] can_tmo, fb_dly;
  logic [3:0] flt_shift;
  logic [10:0][11:0] lut_x, lut_y;
  logic pwm_lowside, trk_use_bak, flt_en, lut_en, fault_sd, sd_to_pos;
  logic dmd_valid, cmd_alarm, cmd_shutdown, limp, src_alarm, trk_err, pri_fail, bak_fail;
  pds_pkg::pds_st_e op_status;
  int fails, check_count, cyc, pend;
  logic [11:0] lin [4] = '{12'h050, 12'h300, 12'h380, 12'hc00};
  logic [11:0] lout [4] = '{12'h000, 12'h300, 12'h3c0, 12'hf00};

  pds_link_if lk();
  pds_host u_pds_host (.clk, .arst_n, .lk(lk), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pds_dev #(.TICK_CYC(TK)) u_pds_dev (.clk, .arst_n, .lk(lk), .pri_src, .bak_src, .ana_range, .ana_fail_lo,
    .ana_fail_hi, .pwm_lowside, .pwm_per_min, .pwm_per_max, .pwm_duty_min, .pwm_duty_max, .pwm_duty_ofs,
    .pwm_duty_zero, .pwm_duty_gain, .can_tmo, .trk_max_diff, .trk_use_bak, .fb_tol, .fb_dly, .flt_en,
    .flt_shift, .lut_en, .lut_x, .lut_y, .fault_sd, .sd_to_pos, .sd_pos, .pos_dmd, .dmd_valid, .op_status,
    .cmd_alarm, .cmd_shutdown, .limp, .src_alarm, .trk_err, .pri_fail, .bak_fail);
  pds_asserts u_pds_asserts (.clk, .arst_n, .can_upd(lk.can_upd), .op_status, .dmd_valid, .cmd_alarm,
    .cmd_shutdown, .limp, .src_alarm, .trk_err, .pri_fail, .bak_fail);

  // Value and status comparisons
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task chk_st(input pds_pkg::pds_st_e e);
    check_count++;
    if (op_status !== e) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, op_status, e);
    end
  endtask : chk_st
  task ck(input pds_pkg::pds_st_e e, input logic [11:0] p);
    chk_st(e);
    chk({20'h0_0000, pos_dmd}, {20'h0_0000, p});
  endtask : ck
  task ticks(input int n);
    repeat (n * TK) @(negedge clk);
  endtask : ticks
  // Ready and answers sampled mid-cycle: they only move on rising edges
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    tb = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb) begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task rd(input logic [4:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    tr = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  task set(input logic [4:0] a, input logic [31:0] d);
    wr(a, d, pds_pkg::RESP_OKAY);
  endtask : set
  task wrap_up;
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Clock, 25 ns period
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard, run needs about 25000 cycles, one 20000-cycle PWM period dominates
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      wrap_up();
    end
  end

  // Main sequence: CAN primary, analog backup
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    pri_src = pds_pkg::SRC_CAN;
    bak_src = pds_pkg::SRC_ANA;
    ana_range = pds_pkg::RNG_5V;
    {ana_fail_lo, ana_fail_hi} = {12'h100, 12'hf00};
    {pwm_lowside, pwm_per_min, pwm_per_max, pwm_duty_min, pwm_duty_max, pwm_duty_ofs} = '0;
    {pwm_duty_zero, pwm_duty_gain, flt_en, flt_shift, lut_en, fault_sd, sd_to_pos} = '0;
    {can_tmo, trk_max_diff, trk_use_bak, fb_tol, fb_dly, sd_pos} = {16'h0003, 12'h200, 1'b0, 12'h040, 16'h0004, 12'h123};
    for (int i = 0; i < 11; i++) begin
      lut_x[i] = 12'(16'h0100 * (i + 1));
      lut_y[i] = 12'(16'h0180 * i);
    end
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(negedge clk);
    chk_st(pds_pkg::ST_ALL_FAIL);
    rd(pds_pkg::OFS_CAN_PER, pds_pkg::CAN_PER_RST, pds_pkg::RESP_OKAY);
    rd(5'h1c, 32'h0000_0000, pds_pkg::RESP_SLVERR);
    wr(pds_pkg::OFS_STAT, 32'h0000_0001, pds_pkg::RESP_SLVERR);
    set(pds_pkg::OFS_ANA, 32'h0000_0800);
    set(pds_pkg::OFS_CAN_POS, 32'h0000_0820);
    set(pds_pkg::OFS_CAN_PER, 32'h0000_0014);
    set(pds_pkg::OFS_CTRL, 32'h0000_0001);
    ticks(3);
    ck(pds_pkg::ST_PRI, 12'h820);
    chk({31'h0, dmd_valid}, 32'h0000_0001);
    set(pds_pkg::OFS_CAN_POS, 32'h0000_0b00);
    ticks(3);
    ck(pds_pkg::ST_PRI_BNTRK, 12'hb00);
    @(posedge clk);
    trk_use_bak <= 1'b1;
    ticks(2);
    ck(pds_pkg::ST_BAK_PNTRK, 12'h800);
    @(posedge clk);
    trk_use_bak <= 1'b0;
    set(pds_pkg::OFS_CTRL, 32'h0000_0000);
    ticks(6);
    ck(pds_pkg::ST_BAK_PFAIL, 12'h800);
    set(pds_pkg::OFS_CAN_POS, 32'h0000_0900);
    set(pds_pkg::OFS_CTRL, 32'h0000_0001);
    ticks(3);
    ck(pds_pkg::ST_FB_INHIB, 12'h800);
    set(pds_pkg::OFS_CAN_POS, 32'h0000_0810);
    // Pending must last exactly the failback delay
    pend = 0;
    for (int n = 0; n < 4 * TK && op_status !== pds_pkg::ST_FB_PEND; n++) @(negedge clk);
    for (int n = 0; n < 10 * TK && op_status === pds_pkg::ST_FB_PEND; n++) @(negedge clk) pend++;
    chk(pend, 4 * TK);
    ticks(1);
    ck(pds_pkg::ST_PRI, 12'h810);
    set(pds_pkg::OFS_ANA, 32'h0000_0f80);
    ticks(3);
    ck(pds_pkg::ST_PRI_BFAIL, 12'h810);
    @(posedge clk);
    bak_src <= pds_pkg::SRC_NONE;
    lut_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      set(pds_pkg::OFS_CAN_POS, {20'h0_0000, lin[i]});
      ticks(3);
      ck(pds_pkg::ST_PRI, lout[i]);
    end
    set(pds_pkg::OFS_CTRL, 32'h0000_0000);
    ticks(6);
    chk_st(pds_pkg::ST_ALL_FAIL);
    chk({31'h0, cmd_alarm}, 32'h0000_0001);
    @(posedge clk);
    fault_sd <= 1'b1;
    sd_to_pos <= 1'b1;
    ticks(2);
    ck(pds_pkg::ST_ALL_FAIL, 12'h123);
    @(posedge clk);
    sd_to_pos <= 1'b0;
    ticks(2);
    chk({31'h0, limp}, 32'h0000_0001);
    // Low-side PWM primary at 2 kHz, half duty plus offset, filtered by halves
    @(posedge clk);
    pri_src <= pds_pkg::SRC_PWM;
    {lut_en, flt_en, flt_shift, pwm_lowside} <= {1'b0, 1'b1, 4'h1, 1'b1};
    {pwm_per_min, pwm_per_max, pwm_duty_max} <= {19'h0_2710, 19'h3_0d40, 13'h1000};
    {pwm_duty_ofs, pwm_duty_gain} <= {12'h010, 12'h100};
    set(pds_pkg::OFS_PWM_PER, 32'h0000_4e20);
    set(pds_pkg::OFS_PWM_HIGH, 32'h0000_2710);
    set(pds_pkg::OFS_CTRL, 32'h0000_0002);
    while (op_status !== pds_pkg::ST_PRI) @(negedge clk);
    @(negedge clk);
    ck(pds_pkg::ST_PRI, 12'ha08);
    ticks(20);
    ck(pds_pkg::ST_PRI, 12'h810);
    chk({31'h0, limp}, 32'h0000_0000);
    wrap_up();
  end
endmodule : pds_test
